// ### rtl/temp_monitor_pkg.sv
// Constants shared by the thermometer register and alarm block.
// Assumes a 20 MHz system clock and a byte-level serial slave in front.
package temp_monitor_pkg;

    // ****************************************
    // Read addresses
    // ****************************************
    localparam logic [7:0] RD_LOCAL_TEMP    = 8'h00;
    localparam logic [7:0] RD_REMOTE_TEMP   = 8'h01;
    localparam logic [7:0] RD_ALARM_FLAGS   = 8'h02;
    localparam logic [7:0] RD_SETUP         = 8'h03;
    localparam logic [7:0] RD_RATE          = 8'h04;
    localparam logic [7:0] RD_LOCAL_UPPER   = 8'h05;
    localparam logic [7:0] RD_LOCAL_LOWER   = 8'h06;
    localparam logic [7:0] RD_REMOTE_UPPER  = 8'h07;
    localparam logic [7:0] RD_REMOTE_LOWER  = 8'h08;
    localparam logic [7:0] RD_CORRECTION    = 8'h11;
    localparam logic [7:0] RD_MAKER_CODE    = 8'hfe;
    localparam logic [7:0] RD_REVISION      = 8'hff;

    // ****************************************
    // Write addresses
    // ****************************************
    localparam logic [7:0] WR_SETUP         = 8'h09;
    localparam logic [7:0] WR_RATE          = 8'h0a;
    localparam logic [7:0] WR_LOCAL_UPPER   = 8'h0b;
    localparam logic [7:0] WR_LOCAL_LOWER   = 8'h0c;
    localparam logic [7:0] WR_REMOTE_UPPER  = 8'h0d;
    localparam logic [7:0] WR_REMOTE_LOWER  = 8'h0e;
    localparam logic [7:0] WR_SINGLE_CONV   = 8'h0f;
    localparam logic [7:0] WR_CORRECTION    = 8'h11;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_TEMP         = 8'h80;
    localparam logic [7:0] RST_SETUP        = 8'h00;
    localparam logic [7:0] RST_RATE         = 8'h02;
    localparam logic [7:0] RST_UPPER        = 8'h7f;
    localparam logic [7:0] RST_LOWER        = 8'hc9;
    localparam logic [7:0] RST_CORRECTION   = 8'h00;
    localparam logic [7:0] RST_POINTER      = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_BUSY          = 7;
    localparam int BIT_LOCAL_OVER    = 6;
    localparam int BIT_LOCAL_UNDER   = 5;
    localparam int BIT_REMOTE_OVER   = 4;
    localparam int BIT_REMOTE_UNDER  = 3;
    localparam int BIT_SENSOR_OPEN   = 2;
    localparam int BIT_SUPPRESS      = 7;
    localparam int BIT_STANDBY       = 6;
    localparam int RATE_MSB          = 2;
    localparam logic [2:0] RATE_FASTEST = 3'h7;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ            = 20000000;
    localparam int FAST_PERIOD_MS    = 125;
    localparam int FAST_PERIOD_CYC   = (CLK_HZ / 1000) * FAST_PERIOD_MS;

    localparam logic [7:0] TEMP_MAX  = 8'h7f;

endpackage

// ### rtl/temp_monitor_register_alarm.sv
// Register file, conversion scheduler and alarm latch of a two-channel thermometer.
// Assumes a serial slave delivering written bytes and read strobes on mclk,
// and a converter front end answering conv_start with conv_done and samples.
`timescale 1ns/100ps
`default_nettype none

// How it works
// [R1] Results are 8-bit twos complement, 1 C per LSB; samples clamp to 0..127 before correction.
// [R2] Both result registers reset to 0x80 until the first conversion writes them.
// [R3] Read and write addresses differ except correction at 11; wrong-direction reads give zero, writes change nothing.
// [R4] Host must not write addresses above 0x0F; the code also accepts writes to the correction register at 0x11.
// [R5] First byte of each write loads the pointer; it steers later write and reads.
// [R6] Host must load the pointer before reading.
// [R7] Result registers are updated by the converter only, read-only over the bus.
// [R8] Status bit 7 reads one while a conversion runs.
// [R9] Status bits 6..2: local over, local under, remote over, remote under, open.
// [R10] Limit flag sets when a result is above its high or below its low limit.
// [R11] Open flag sets while the remote diode is disconnected.
// [R12] Any flag sets the alarm latch; a set latch drives alarm_n low.
// [R13] Status read clears flags whose cause is gone; persisting causes stay set.
// [R14] Flags are sticky until status read or reset.
// [R15] Latch clears only on alert response read, with causes and flags gone.
// [R16] Setup bit 7 masks present and future alarms while set.
// [R17] Defaults: setup 00, rate 02, highs 7F, lows C9, correction 00.
// [R18] Setup, rate, limits read at 03..08, written at 09..0E; correction at 11.
// [R19] A write to 0F starts one conversion; data is discarded.
// [R20] Running at power-up converts at once; standby pin low stops periodic conversions, one-shots still write results.
// [R21] Revision register: upper nibble part type, lower nibble die revision.
// [R22] High check trips on strictly greater, low on strictly smaller.
// [R23] Setup bit 6 set halts periodic conversions; a write to 0F still converts and updates results.
// [R24] Rate bits 2..0 divide the conversion clock, 0 slowest, 7 fastest.
// [R25] The signed correction is added to every remote result before storing.
// [R26] Reserved reads give zero; reserved writes change nothing.
module temp_monitor_register_alarm
    import temp_monitor_pkg::*;
#(
    parameter int         BASE_CYCLES = FAST_PERIOD_CYC,
    parameter logic [7:0] MAKER_ID    = 8'h5a,  // Arbitrary value
    parameter logic [3:0] PART_TYPE   = 4'h6,   // Arbitrary value
    parameter logic [3:0] DIE_REV     = 4'h1    // Arbitrary value
) (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       wr_valid,
    input  wire logic       wr_first,
    input  wire logic [7:0] wr_data,
    input  wire logic       rd_strobe,
    output logic      [7:0] rd_data,
    input  wire logic       alert_ack,
    input  wire logic       standby_pin_n,
    output logic            conv_start,
    input  wire logic       conv_done,
    input  wire logic [7:0] local_sample,
    input  wire logic [7:0] remote_sample,
    input  wire logic       sensor_open,
    output logic            alarm_n
);

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0]  local_temp_result;
    logic [7:0]  remote_temp_result;
    logic [7:0]  device_setup;
    logic [7:0]  sample_rate_select;
    logic [7:0]  local_upper_limit;
    logic [7:0]  local_lower_limit;
    logic [7:0]  remote_upper_limit;
    logic [7:0]  remote_lower_limit;
    logic [7:0]  remote_correction;
    logic [7:0]  register_pointer;
    logic        local_over_flag;
    logic        local_under_flag;
    logic        remote_over_flag;
    logic        remote_under_flag;
    logic        open_flag;
    logic        alarm_latch;
    logic        busy;
    logic        single_pending;
    logic        standby_pin_n_meta;
    logic        standby_pin_sync;
    logic [31:0] period_count;

    logic        alarm_suppress_bit;
    logic        running;
    logic        period_tick;
    logic        reg_write;
    logic        status_read;
    logic        cause_lo;
    logic        cause_lu;
    logic        cause_ro;
    logic        cause_ru;
    logic        any_cause;
    logic        any_flag;
    logic [31:0] period_len;
    logic [7:0]  local_clamped;
    logic [7:0]  remote_clamped;
    logic [8:0]  remote_sum;
    logic [7:0]  remote_corrected;
    logic [7:0]  next_rd_data;

    assign alarm_suppress_bit = device_setup[BIT_SUPPRESS];
    assign reg_write   = wr_valid && !wr_first;
    assign status_read = rd_strobe && (register_pointer == RD_ALARM_FLAGS);

    // ****************************************
    // Standby pin synchroniser
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            standby_pin_n_meta        <= 1'b0;
            standby_pin_sync <= 1'b0;
        end else begin
            standby_pin_n_meta        <= standby_pin_n;
            standby_pin_sync <= standby_pin_n_meta;
        end
    end

    assign running = standby_pin_sync && !device_setup[BIT_STANDBY]; // [R23]

    // ****************************************
    // Pointer and writable registers
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            register_pointer <= RST_POINTER;
        end else if (wr_valid && wr_first) begin
            register_pointer <= wr_data; // [R5]
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            device_setup       <= RST_SETUP; // [R17]
            sample_rate_select <= RST_RATE;
            local_upper_limit  <= RST_UPPER;
            local_lower_limit  <= RST_LOWER;
            remote_upper_limit <= RST_UPPER;
            remote_lower_limit <= RST_LOWER;
            remote_correction  <= RST_CORRECTION;
        end else if (reg_write) begin
            // Only write addresses are decoded; read addresses fall through
            unique case (register_pointer) // [R18] [R3] [R26]
                WR_SETUP:        device_setup       <= wr_data;
                WR_RATE:         sample_rate_select <= wr_data;
                WR_LOCAL_UPPER:  local_upper_limit  <= wr_data;
                WR_LOCAL_LOWER:  local_lower_limit  <= wr_data;
                WR_REMOTE_UPPER: remote_upper_limit <= wr_data;
                WR_REMOTE_LOWER: remote_lower_limit <= wr_data;
                WR_CORRECTION:   remote_correction  <= wr_data;
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Conversion scheduling
    // ****************************************
    assign period_len = BASE_CYCLES << (RATE_FASTEST - sample_rate_select[RATE_MSB:0]); // [R24]
    assign period_tick = running && (period_count == 32'h0);

    always_ff @(posedge mclk) begin
        if (srst) begin
            period_count <= 32'h0; // [R20]
        end else if (!running) begin
            period_count <= 32'h0;
        end else if (period_tick || period_count >= period_len) begin
            period_count <= period_len - 32'h1;
        end else begin
            period_count <= period_count - 32'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            single_pending <= 1'b0;
        end else if (reg_write && register_pointer == WR_SINGLE_CONV) begin
            single_pending <= 1'b1; // [R19]
        end else if (conv_start) begin
            single_pending <= 1'b0;
        end
    end

    // One-shot requests arriving while busy wait for the running conversion to end; period ticks are dropped
    assign conv_start = !busy && (period_tick || single_pending);

    always_ff @(posedge mclk) begin
        if (srst) begin
            busy <= 1'b0;
        end else if (conv_start) begin
            busy <= 1'b1; // [R8]
        end else if (conv_done) begin
            busy <= 1'b0;
        end
    end

    // ****************************************
    // Result capture
    // ****************************************
    // Negative samples are out of the measuring range and clamp to zero
    assign local_clamped  = local_sample[7]  ? 8'h00 : local_sample;  // [R1]
    assign remote_clamped = remote_sample[7] ? 8'h00 : remote_sample; // [R1]
    assign remote_sum = {1'b0, remote_clamped} + {remote_correction[7], remote_correction};
    // Saturate instead of wrapping past the signed range
    assign remote_corrected = (remote_sum[8] != remote_sum[7]) ?
                              (remote_sum[8] ? 8'h80 : TEMP_MAX) : remote_sum[7:0]; // [R25]

    always_ff @(posedge mclk) begin
        if (srst) begin
            local_temp_result  <= RST_TEMP; // [R2]
            remote_temp_result <= RST_TEMP;
        end else if (busy && conv_done) begin
            local_temp_result  <= local_clamped; // [R7]
            remote_temp_result <= remote_corrected; // [R7]
        end
    end

    // ****************************************
    // Limit flags and alarm latch
    // ****************************************
    assign cause_lo = $signed(local_temp_result)  > $signed(local_upper_limit);  // [R22]
    assign cause_lu = $signed(local_temp_result)  < $signed(local_lower_limit);  // [R22]
    assign cause_ro = $signed(remote_temp_result) > $signed(remote_upper_limit); // [R22]
    assign cause_ru = $signed(remote_temp_result) < $signed(remote_lower_limit); // [R22]
    assign any_cause = cause_lo || cause_lu || cause_ro || cause_ru || sensor_open;
    assign any_flag  = local_over_flag || local_under_flag || remote_over_flag ||
                       remote_under_flag || open_flag;

    // A present cause always wins over a clearing read
    always_ff @(posedge mclk) begin
        if (srst) begin
            local_over_flag   <= 1'b0;
            local_under_flag  <= 1'b0;
            remote_over_flag  <= 1'b0;
            remote_under_flag <= 1'b0;
            open_flag         <= 1'b0;
        end else begin
            local_over_flag   <= cause_lo    || (local_over_flag   && !status_read); // [R10] [R13] [R14]
            local_under_flag  <= cause_lu    || (local_under_flag  && !status_read); // [R10] [R13] [R14]
            remote_over_flag  <= cause_ro    || (remote_over_flag  && !status_read); // [R10] [R13] [R14]
            remote_under_flag <= cause_ru    || (remote_under_flag && !status_read); // [R10] [R13] [R14]
            open_flag         <= sensor_open || (open_flag         && !status_read); // [R11] [R13] [R14]
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            alarm_latch <= 1'b0;
        end else if (any_flag) begin
            alarm_latch <= 1'b1; // [R12]
        end else if (alert_ack && !any_cause) begin
            alarm_latch <= 1'b0; // [R15]
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            alarm_n <= 1'b1;
        end else begin
            alarm_n <= !(alarm_latch && !alarm_suppress_bit); // [R12] [R16]
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        unique case (register_pointer)
            RD_LOCAL_TEMP:   next_rd_data = local_temp_result;
            RD_REMOTE_TEMP:  next_rd_data = remote_temp_result;
            RD_ALARM_FLAGS:  next_rd_data = {busy, local_over_flag, local_under_flag,
                                             remote_over_flag, remote_under_flag,
                                             open_flag, 2'b00}; // [R9] [R8]
            RD_SETUP:        next_rd_data = device_setup;
            RD_RATE:         next_rd_data = sample_rate_select;
            RD_LOCAL_UPPER:  next_rd_data = local_upper_limit;
            RD_LOCAL_LOWER:  next_rd_data = local_lower_limit;
            RD_REMOTE_UPPER: next_rd_data = remote_upper_limit;
            RD_REMOTE_LOWER: next_rd_data = remote_lower_limit;
            RD_CORRECTION:   next_rd_data = remote_correction;
            RD_MAKER_CODE:   next_rd_data = MAKER_ID;
            RD_REVISION:     next_rd_data = {PART_TYPE, DIE_REV}; // [R21]
            default:         next_rd_data = 8'h00; // [R26] [R3]
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rd_data <= 8'h00;
        end else if (rd_strobe) begin
            rd_data <= next_rd_data;
        end
    end

endmodule

`default_nettype wire

// ### verification/temp_monitor_properties.sv
// Port-level checks for the thermometer register and alarm block.
// Assumes binding into temp_monitor_register_alarm with its identity parameters.
`timescale 1ns/100ps
`default_nettype none
module temp_monitor_properties
    import temp_monitor_pkg::*;
#(
    parameter logic [7:0] MAKER_ID  = 8'h5a,
    parameter logic [3:0] PART_TYPE = 4'h6,
    parameter logic [3:0] DIE_REV   = 4'h1
) (
    input wire logic       mclk,
    input wire logic       srst,
    input wire logic       wr_valid,
    input wire logic       wr_first,
    input wire logic [7:0] wr_data,
    input wire logic       rd_strobe,
    input wire logic [7:0] rd_data,
    input wire logic       alert_ack,
    input wire logic       conv_start,
    input wire logic       conv_done,
    input wire logic       sensor_open,
    input wire logic       alarm_n
);
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    sequence ptr_then_read(logic [7:0] p);
        wr_valid && wr_first && wr_data == p ##1 rd_strobe;
    endsequence
    a_reset_outputs: assert property (disable iff (1'b0)
        srst |=> rd_data == 8'h00 && alarm_n) else $error("outputs not at reset level");
    a_read_holds: assert property (!rd_strobe |=> $stable(rd_data))
        else $error("read data moved without a strobe");
    a_start_single: assert property (conv_start |=> !conv_start until_with conv_done)
        else $error("conversion started while busy");
    a_alarm_release: assert property ($rose(alarm_n) |-> $past(alert_ack, 2)
        || $past(wr_valid, 2) || $past(srst) || $past(srst, 2))
        else $error("alarm released without ack or mask");
    a_maker_read: assert property (ptr_then_read(RD_MAKER_CODE) |=> rd_data == MAKER_ID)
        else $error("maker code wrong");
    a_revision_read: assert property (ptr_then_read(RD_REVISION)
        |=> rd_data == {PART_TYPE, DIE_REV}) else $error("revision code wrong");
    a_unmapped_read: assert property (ptr_then_read(8'h10) |=> rd_data == 8'h00)
        else $error("reserved read not zero");
    a_wrong_dir_read: assert property (ptr_then_read(WR_SETUP) |=> rd_data == 8'h00)
        else $error("write address read not zero");
    a_open_sticks: assert property (ptr_then_read(RD_ALARM_FLAGS) ##0 (sensor_open
        && $past(sensor_open) && $past(sensor_open, 2))
        |=> rd_data[BIT_SENSOR_OPEN] && rd_data[1:0] == 2'b00)
        else $error("open flag lost while open");
endmodule
bind temp_monitor_register_alarm temp_monitor_properties #(
    .MAKER_ID(MAKER_ID), .PART_TYPE(PART_TYPE), .DIE_REV(DIE_REV)
) i_props (.mclk(mclk), .srst(srst), .wr_valid(wr_valid), .wr_first(wr_first),
    .wr_data(wr_data), .rd_strobe(rd_strobe), .rd_data(rd_data), .alert_ack(alert_ack),
    .conv_start(conv_start), .conv_done(conv_done), .sensor_open(sensor_open),
    .alarm_n(alarm_n));
`default_nettype wire

// ### verification/temp_conv_model.sv
// Behavioural converter front end answering conv_start after a set latency.
// Assumes the bench supplies raw values and a latency of at least one cycle.
`timescale 1ns/100ps
`default_nettype none
module temp_conv_model (
    input  wire logic       mclk,
    input  wire logic       conv_start,
    input  wire logic [3:0] lat,
    input  wire logic [7:0] loc_val,
    input  wire logic [7:0] rem_val,
    output logic            conv_done,
    output logic      [7:0] local_sample,
    output logic      [7:0] remote_sample
);
    // ****************************************
    // Conversion timing
    // ****************************************
    logic [3:0] cnt = 4'h0;
    always @(posedge mclk) begin
        conv_done <= cnt == 4'h1;
        if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (conv_start) begin
            cnt <= lat;
        end
    end
    // Samples only mean something beside conv_done
    assign local_sample  = conv_done ? loc_val : ~loc_val;
    assign remote_sample = conv_done ? rem_val : ~rem_val;
endmodule
`default_nettype wire

// ### verification/temp_monitor_register_alarm_tb.sv
// Self-checking bench for the thermometer register and alarm block.
// Assumes the converter model on the sample side and a shortened base period.
`timescale 1ns/100ps
`default_nettype none
module temp_monitor_register_alarm_tb;
    import temp_monitor_pkg::*;
    localparam int BASE = 16;
    logic       mclk, srst, wr_valid, wr_first, rd_strobe, alert_ack, standby_pin_n;
    logic       conv_start, conv_done, sensor_open, alarm_n;
    logic [7:0] wr_data, rd_data, local_sample, remote_sample, loc_val, rem_val, seen, corr, b;
    logic [3:0] lat;
    int         num_errors, comparisons, n, seed;
    logic [7:0] ra [14] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                            8'h08, 8'h11, 8'hfe, 8'hff, 8'h10, 8'h09, 8'h0f};
    logic [7:0] rv [14] = '{8'h80, 8'h80, 8'h00, 8'h02, 8'h7f, 8'hc9, 8'h7f,
                            8'hc9, 8'h00, 8'h5a, 8'h61, 8'h00, 8'h00, 8'h00};
    logic [7:0] cv [5]  = '{8'h50, 8'h51, 8'h10, 8'h0f, 8'h9c};
    temp_monitor_register_alarm #(.BASE_CYCLES(BASE)) i_dut (
        .mclk(mclk), .srst(srst), .wr_valid(wr_valid), .wr_first(wr_first),
        .wr_data(wr_data), .rd_strobe(rd_strobe), .rd_data(rd_data), .alert_ack(alert_ack),
        .standby_pin_n(standby_pin_n), .conv_start(conv_start), .conv_done(conv_done),
        .local_sample(local_sample), .remote_sample(remote_sample),
        .sensor_open(sensor_open), .alarm_n(alarm_n));
    temp_conv_model i_conv (.mclk(mclk), .conv_start(conv_start), .lat(lat),
        .loc_val(loc_val), .rem_val(rem_val), .conv_done(conv_done),
        .local_sample(local_sample), .remote_sample(remote_sample));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic cyc(input int k = 1);
        repeat (k) @(posedge mclk);
        #5;
    endtask
    task automatic check(input string what, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_valid = 1'b1;
        wr_first = 1'b1;
        wr_data  = a;
        cyc();
        wr_first = 1'b0;
        wr_data  = d;
        cyc();
        wr_valid = 1'b0;
        cyc();
    endtask
    task automatic rd(input logic [7:0] a);
        wr_valid  = 1'b1;
        wr_first  = 1'b1;
        wr_data   = a;
        cyc();
        wr_valid  = 1'b0;
        rd_strobe = 1'b1;
        cyc();
        rd_strobe = 1'b0;
        seen      = rd_data;
    endtask
    task automatic ack();
        alert_ack = 1'b1;
        cyc();
        alert_ack = 1'b0;
        cyc(3);
    endtask
    task automatic al(input logic e);
        check("alarm_n", {7'h0, alarm_n}, {7'h0, e});
    endtask
    task automatic wait_for(input logic s);
        for (n = 0; n < 900 && (s ? conv_start : conv_done) !== 1'b1; n++) cyc();
        if (n == 900) check("handshake", 8'h00, 8'h01);
    endtask
    function automatic logic [7:0] exp_temp(input logic [7:0] v, input logic [7:0] c);
        return v[7] ? 8'h00 : ({1'b0, v} + c > 9'd127 ? 8'h7f : v + c);
    endfunction
    function automatic logic [7:0] exp_flags(input logic [7:0] l, input logic [7:0] r);
        return {1'b0, exp_temp(l, 8'h00) > 8'h50, exp_temp(l, 8'h00) < 8'h10,
                exp_temp(r, corr) > 8'h50, exp_temp(r, corr) < 8'h10, 3'b000};
    endfunction
    task automatic summarize();
        if (num_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        repeat (30000) @(posedge mclk);
        num_errors++;
        summarize();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {wr_valid, wr_first, rd_strobe, alert_ack, standby_pin_n, sensor_open} = '0;
        {wr_data, loc_val, rem_val, corr} = '0;
        srst        = 1'b1;
        lat         = 4'd6;
        num_errors  = 0;
        comparisons = 0;
        seed        = $urandom(32'h75471b73);
        cyc(12);
        srst = 1'b0;
        cyc();
        foreach (ra[i]) begin
            rd(ra[i]);
            check("reg", seen, rv[i]);
        end
        rd(RD_ALARM_FLAGS);
        check("standby_flags", seen, 8'h28);
        al(1'b0);
        for (int a = 9; a <= 14; a++) begin
            b = 8'($urandom);
            wr(8'(a), b);
            rd(8'(a - 6));
            check("rw", seen, b);
        end
        wr(RD_LOCAL_TEMP, 8'h55);
        rd(RD_LOCAL_TEMP);
        check("read_only", seen, 8'h80);
        wr(WR_SETUP, 8'h00);
        wr(WR_RATE, 8'h07);
        for (int a = 11; a <= 14; a++) wr(8'(a), a[0] ? 8'h50 : 8'h10);
        corr = 8'($urandom_range(7));
        wr(WR_CORRECTION, corr);
        rd(RD_CORRECTION);
        check("correction", seen, corr);
        standby_pin_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            loc_val = i < 5 ? cv[i % 5] : 8'($urandom);
            rem_val = i == 0 ? 8'h7e : 8'($urandom_range(127));
            wait_for(1'b0);
            cyc(3);
            rd(RD_LOCAL_TEMP);
            check("local", seen, exp_temp(loc_val, 8'h00));
            rd(RD_REMOTE_TEMP);
            check("remote", seen, exp_temp(rem_val, corr));
            rd(RD_ALARM_FLAGS);
            rd(RD_ALARM_FLAGS);
            check("flags", {1'b0, seen[6:0]}, exp_flags(loc_val, rem_val));
        end
        for (int r = 7; r >= 6; r--) begin
            wr(WR_RATE, 8'(r));
            repeat (2) begin
                wait_for(1'b1);
                cyc();
            end
            wait_for(1'b1);
            check("period", 8'(n + 1), 8'(BASE << (7 - r)));
        end
        loc_val = 8'h20;
        rem_val = 8'h20;
        wr(WR_SETUP, 8'h40);
        cyc(20);
        n = 0;
        repeat (300) begin
            cyc();
            if (conv_start !== 1'b0) n++;
        end
        check("standby", 8'(n), 8'h00);
        lat = 4'd8;
        wr(WR_SINGLE_CONV, 8'ha5);
        rd(RD_ALARM_FLAGS);
        check("busy", {7'h0, seen[BIT_BUSY]}, 8'h01);
        wait_for(1'b0);
        cyc(3);
        rd(RD_REMOTE_TEMP);
        check("single", seen, exp_temp(8'h20, corr));
        rd(RD_ALARM_FLAGS);
        ack();
        al(1'b1);
        sensor_open = 1'b1;
        cyc(5);
        al(1'b0);
        ack();
        al(1'b0);
        wr(WR_SETUP, 8'hc0);
        al(1'b1);
        wr(WR_SETUP, 8'h40);
        al(1'b0);
        rd(RD_ALARM_FLAGS);
        check("open", seen & 8'h7f, 8'h04);
        sensor_open = 1'b0;
        cyc(3);
        rd(RD_ALARM_FLAGS);
        check("sticky", seen & 8'h7f, 8'h04);
        rd(RD_ALARM_FLAGS);
        check("cleared", seen & 8'h7f, 8'h00);
        al(1'b0);
        ack();
        al(1'b1);
        summarize();
    end
endmodule
`default_nettype wire
